// >>> cpusr_pkg.sv
// shared constants and types for the cpu state and read-modify-write block
package cpusr_pkg;
  // address map
  localparam logic [15:0] ROM_LAST      = 16'h0fff;
  localparam logic [15:0] RAM_BASE      = 16'hff80;
  localparam int          RAM_DEPTH     = 16;
  localparam int          RAM_IDX_W     = 4;
  localparam logic [15:0] PORT_DATA_ADR = 16'hffd8;
  localparam logic [15:0] PORT_DIR_ADR  = 16'hffe8;
  // read answers
  localparam logic [7:0]  ROM_FILL      = 8'h00;
  localparam logic [7:0]  UNMAPPED_READ = 8'hff;
  localparam logic [7:0]  DIR_READ      = 8'hff;
  // values after reset
  localparam logic [7:0]  LATCH_RESET   = 8'h00;
  localparam logic [7:0]  DIR_RESET     = 8'h00;
  // cpu state codes seen at the port
  localparam logic [1:0]  CODE_RESET    = 2'h0;
  localparam logic [1:0]  CODE_EXEC     = 2'h1;
  localparam logic [1:0]  CODE_HALT     = 2'h2;
  localparam logic [1:0]  CODE_EXCEPT   = 2'h3;
  // command opcodes
  localparam logic [2:0]  OP_READ       = 3'h0;
  localparam logic [2:0]  OP_WRITE      = 3'h1;
  localparam logic [2:0]  OP_BIT_SET_INSTRUCTION       = 3'h2;
  localparam logic [2:0]  OP_BIT_CLEAR_INSTRUCTION       = 3'h3;
  localparam logic [2:0]  OP_BIT_INVERT_INSTRUCTION       = 3'h4;
  localparam logic [2:0]  OP_BST        = 3'h5;
  localparam logic [2:0]  OP_BIT_INVERTED_STORE_INSTRUCTION       = 3'h6;
  localparam logic [2:0]  OP_MOVE       = 3'h7;

  typedef enum logic [1:0] {cpu_reset, cpu_exec, cpu_halt, cpu_except} cpusr_cpu_e;
  typedef enum logic [2:0] {ex_idle, ex_rmw_rd, ex_rmw_wr, ex_mv_rd, ex_mv_wr, ex_done} cpusr_exec_e;
endpackage : cpusr_pkg

// >>> cpusr_bus_if.sv
// internal byte bus between the executor and the port
`timescale 1ns/1ps
interface cpusr_bus_if;
  logic [15:0] addr;
  logic [7:0]  wdata;
  logic        we;
  logic [7:0]  rdata;
  logic        hit;

  modport master (output addr, output wdata, output we, input rdata, input hit);
  modport port   (input addr, input wdata, input we, output rdata, output hit);
endinterface : cpusr_bus_if

// >>> cpusr_port.sv
// eight-bit general purpose port: output latch, direction control, pin read mux
`timescale 1ns/1ps
module cpusr_port
  import cpusr_pkg::*;
(
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  // internal bus
  cpusr_bus_if.port       bus,
  // pins
  input  wire logic [7:0] pin_in,
  output logic      [7:0] pin_out,
  output logic      [7:0] pin_oe_n
);
  logic [7:0] port_five_output_latch;
  logic [7:0] port_five_direction_control;

  // address decode
  wire data_sel = (bus.addr == PORT_DATA_ADR);
  wire dir_sel  = (bus.addr == PORT_DIR_ADR);
  // per bit: output bits read the latch, input bits read the pin
  wire [7:0] data_view = (port_five_direction_control & port_five_output_latch)
                       | (~port_five_direction_control & pin_in);

  assign bus.hit   = data_sel | dir_sel;
  // direction control is write-only, so a read sees all ones
  assign bus.rdata = dir_sel ? DIR_READ : (data_sel ? data_view : 8'h00);

  // a byte write updates all eight latch bits even where the pin is an input
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      port_five_output_latch      <= LATCH_RESET;
      port_five_direction_control <= DIR_RESET;
    end else if (bus.we && data_sel) begin
      port_five_output_latch <= bus.wdata;
    end else if (bus.we && dir_sel) begin
      port_five_direction_control <= bus.wdata;
    end
  end

  // pin drivers registered so the outputs come from flops; enable low = driven
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pin_out  <= LATCH_RESET;
      pin_oe_n <= ~DIR_RESET;
    end else begin
      pin_out  <= (bus.we && data_sel) ? bus.wdata : port_five_output_latch;
      pin_oe_n <= (bus.we && dir_sel) ? ~bus.wdata : ~port_five_direction_control;
    end
  end
endmodule : cpusr_port

// >>> cpusr_core.sv
// cpu state tracker with block move, bit read-modify-write and memory map
// Behaviour
// - cpu always in one of four states
// - unmapped writes dropped, unmapped reads undefined
// - block move copies count bytes source to destination
// - bit ops read byte, change bit, write back
// - port read returns pin level for inputs
// - port read returns latch for output bits
// - byte write updates all eight latch bits
// - output pin drives latch value level
// - direction zero input, one output
// - direction register reads back all ones
`timescale 1ns/1ps
module cpusr_core
  import cpusr_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  // command port
  input  wire logic        cmd_valid,
  input  wire logic [2:0]  cmd_op,
  input  wire logic [15:0] cmd_addr,
  input  wire logic [15:0] cmd_dst,
  input  wire logic [2:0]  cmd_bit,
  input  wire logic [7:0]  cmd_data,
  output logic             cmd_ready,
  output logic             done,
  output logic      [7:0]  rsp_data,
  // state control
  input  wire logic        halt_req,
  input  wire logic        halt_standby,
  input  wire logic        wake,
  input  wire logic        exc_req,
  output logic      [1:0]  cpu_state_code,
  output logic             standby_mode,
  // port pins
  input  wire logic [7:0]  pin_in,
  output logic      [7:0]  pin_out,
  output logic      [7:0]  pin_oe_n
);
  ////////////////////////////////////////////////////////////////////////////////
  // declarations
  cpusr_bus_if bus ();
  cpusr_cpu_e  cpu_st, next_cpu_st;
  cpusr_exec_e ex_st, next_ex_st;
  logic [2:0]  op;
  logic [2:0]  bit_sel;
  logic        carry;
  logic [15:0] src_ptr;
  logic [15:0] dst_ptr;
  logic [7:0]  count;
  logic [7:0]  hold;
  logic [7:0]  ram [RAM_DEPTH];

  ////////////////////////////////////////////////////////////////////////////////
  // cpu state machine: exactly one of four states at all times
  wire idle_exec = (cpu_st == cpu_exec) && (ex_st == ex_idle);
  always_comb begin
    next_cpu_st = cpu_st;
    case (cpu_st)
      cpu_reset:  next_cpu_st = cpu_except;
      cpu_except: next_cpu_st = cpu_exec;
      cpu_exec: begin
        if (idle_exec && !cmd_valid && exc_req) next_cpu_st = cpu_except;
        else if (idle_exec && !cmd_valid && halt_req) next_cpu_st = cpu_halt;
      end
      cpu_halt:   if (wake) next_cpu_st = cpu_except;
      default:    next_cpu_st = cpu_reset;
    endcase
  end

  wire [1:0] next_code = (next_cpu_st == cpu_exec) ? CODE_EXEC :
                         (next_cpu_st == cpu_halt) ? CODE_HALT :
                         (next_cpu_st == cpu_except) ? CODE_EXCEPT : CODE_RESET;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cpu_st         <= cpu_reset;
      cpu_state_code <= CODE_RESET;
      standby_mode   <= 1'b0;
    end else begin
      cpu_st         <= next_cpu_st;
      cpu_state_code <= next_code;
      if (cpu_st == cpu_exec && next_cpu_st == cpu_halt) standby_mode <= halt_standby;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // address decode; ram and port are the writable areas, rom is read only
  wire        take      = idle_exec && cmd_valid;
  wire        in_rmw_rd = (ex_st == ex_rmw_rd);
  wire        in_rmw_wr = (ex_st == ex_rmw_wr);
  wire        in_mv_rd  = (ex_st == ex_mv_rd);
  wire        in_mv_wr  = (ex_st == ex_mv_wr);
  wire [15:0] acc_addr  = in_mv_rd ? src_ptr : (in_mv_wr ? dst_ptr : (take ? cmd_addr : src_ptr));
  wire        ram_hit   = (acc_addr >= RAM_BASE) && (acc_addr < RAM_BASE + 16'(RAM_DEPTH));
  wire        rom_hit   = (acc_addr <= ROM_LAST);
  wire [15:0] ram_off   = acc_addr - RAM_BASE;
  wire [RAM_IDX_W-1:0] ram_idx = ram_off[RAM_IDX_W-1:0];

  // unmapped reads return a fixed filler; software may not rely on it
  wire [7:0]  rd_data   = ram_hit ? ram[ram_idx] :
                          bus.hit ? bus.rdata :
                          rom_hit ? ROM_FILL : UNMAPPED_READ;

  // bit modify on the byte just read; only the selected bit changes
  wire [7:0]  bit_mask  = 8'h01 << bit_sel;
  wire [7:0]  mod_set   = hold | bit_mask;
  wire [7:0]  mod_clr   = hold & ~bit_mask;
  wire [7:0]  mod_not   = hold ^ bit_mask;
  wire [7:0]  mod_st    = carry ? mod_set : mod_clr;
  wire [7:0]  mod_ist   = carry ? mod_clr : mod_set;
  wire [7:0]  modified  = (op == OP_BIT_SET_INSTRUCTION) ? mod_set :
                          (op == OP_BIT_CLEAR_INSTRUCTION) ? mod_clr :
                          (op == OP_BIT_INVERT_INSTRUCTION) ? mod_not :
                          (op == OP_BST)  ? mod_st  : mod_ist;

  // a write happens on a plain write, a bit op write-back or a move write
  wire        wr_now    = (take && cmd_op == OP_WRITE) || in_rmw_wr || in_mv_wr;
  wire [7:0]  wr_data   = in_rmw_wr ? modified : (in_mv_wr ? hold : cmd_data);

  assign bus.addr  = acc_addr;
  assign bus.wdata = wr_data;
  assign bus.we    = wr_now; // writes outside ram and port decode nowhere

  ////////////////////////////////////////////////////////////////////////////////
  // executor: commands are only taken when idle, so a bit op owns the bus
  // from its read to its write-back with no access between them
  always_comb begin
    next_ex_st = ex_st;
    case (ex_st)
      ex_idle: begin
        if (take) begin
          if (cmd_op == OP_READ || cmd_op == OP_WRITE) next_ex_st = ex_done;
          else if (cmd_op == OP_MOVE) next_ex_st = (cmd_data == 8'h00) ? ex_done : ex_mv_rd;
          else next_ex_st = ex_rmw_rd;
        end
      end
      ex_rmw_rd: next_ex_st = ex_rmw_wr;
      ex_rmw_wr: next_ex_st = ex_done;
      ex_mv_rd:  next_ex_st = ex_mv_wr;
      ex_mv_wr:  next_ex_st = (count == 8'h01) ? ex_done : ex_mv_rd;
      ex_done:   next_ex_st = ex_idle;
      default:   next_ex_st = ex_idle;
    endcase
  end

  // command capture and pointer stepping; destination wrap is left to software
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ex_st   <= ex_idle;
      op      <= OP_READ;
      bit_sel <= 3'h0;
      carry   <= 1'b0;
      src_ptr <= 16'h0000;
      dst_ptr <= 16'h0000;
      count   <= 8'h00;
    end else begin
      ex_st <= next_ex_st;
      if (take) begin
        op      <= cmd_op;
        bit_sel <= cmd_bit;
        carry   <= cmd_data[0];
        src_ptr <= cmd_addr;
        dst_ptr <= cmd_dst;
        count   <= cmd_data;
      end else if (in_mv_wr) begin
        src_ptr <= src_ptr + 16'h0001;
        dst_ptr <= dst_ptr + 16'h0001;
        count   <= count - 8'h01;
      end
    end
  end

  // byte held between read and write of a bit op or move step
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      hold <= 8'h00;
    end else if (in_rmw_rd || in_mv_rd) begin
      hold <= rd_data;
    end
  end

  // handshake outputs, all registered
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cmd_ready <= 1'b0;
      done      <= 1'b0;
      rsp_data  <= 8'h00;
    end else begin
      cmd_ready <= (next_cpu_st == cpu_exec) && (next_ex_st == ex_idle) && !(take && next_ex_st == ex_idle);
      done      <= (ex_st == ex_done);
      if (take && cmd_op == OP_READ) rsp_data <= rd_data;
      else if (in_rmw_wr) rsp_data <= modified;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // ram in flip-flops, one write enable per entry
  for (genvar i = 0; i < RAM_DEPTH; i++) begin : g_ram
    always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
        ram[i] <= 8'h00;
      end else if (wr_now && ram_hit && ram_idx == RAM_IDX_W'(i)) begin
        ram[i] <= wr_data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // general purpose port
  cpusr_port u_port (
    .ref_clk  (ref_clk),
    .nrst     (nrst),
    .bus      (bus.port),
    .pin_in   (pin_in),
    .pin_out  (pin_out),
    .pin_oe_n (pin_oe_n)
  );
endmodule : cpusr_core

// >>> cpusr_sva.sv
// port-level assertions for the cpu state and read-modify-write core
`timescale 1ns/1ps
module cpusr_sva
  import cpusr_pkg::*;
(
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        nrst,
  // command port
  input wire logic        cmd_valid,
  input wire logic [2:0]  cmd_op,
  input wire logic [15:0] cmd_addr,
  input wire logic [7:0]  cmd_data,
  input wire logic        cmd_ready,
  input wire logic        done,
  input wire logic [7:0]  rsp_data,
  // state and pins
  input wire logic        halt_req,
  input wire logic        exc_req,
  input wire logic [1:0]  cpu_state_code,
  input wire logic [7:0]  pin_in,
  input wire logic [7:0]  pin_out,
  input wire logic [7:0]  pin_oe_n
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////////////////////
  // decoded takes; the taken byte is held so a late pin update can be compared
  wire take     = cmd_valid && cmd_ready;
  wire wr_take  = take && (cmd_op == OP_WRITE);
  wire rd_take  = take && (cmd_op == OP_READ);
  wire bit_take = take && (cmd_op >= OP_BIT_SET_INSTRUCTION) && (cmd_op <= OP_BIT_INVERTED_STORE_INSTRUCTION);
  wire in_ram   = (cmd_addr >= RAM_BASE) && (cmd_addr <= RAM_BASE + 16'h000f);
  wire unmapped = (cmd_addr > ROM_LAST) && !in_ram && (cmd_addr != PORT_DATA_ADR) && (cmd_addr != PORT_DIR_ADR);
  logic [7:0] last_wd;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) last_wd <= 8'h00;
    else if (take) last_wd <= cmd_data;
  end
  ////////////////////////////////////////////////////////////////////////////////
  chk_reset_exit: assert property (!$past(nrst) |-> cpu_state_code == CODE_RESET && pin_oe_n == 8'hff
    && pin_out == 8'h00 ##1 cpu_state_code == CODE_EXCEPT ##1 cpu_state_code == CODE_EXEC) else $error("bad reset exit");
  chk_ready_exec: assert property (cmd_ready |-> cpu_state_code == CODE_EXEC) else $error("ready outside exec");
  chk_halt_entry: assert property (cmd_ready && halt_req && !cmd_valid && !exc_req |-> ##[1:2]
    cpu_state_code == CODE_HALT) else $error("halt not entered");
  chk_dir_read: assert property (rd_take && cmd_addr == PORT_DIR_ADR |-> ##2 done && rsp_data == DIR_READ)
    else $error("direction read not all ones");
  chk_port_read: assert property (rd_take && cmd_addr == PORT_DATA_ADR |-> ##2 done && rsp_data ==
    (($past(pin_in, 2) & $past(pin_oe_n, 2)) | ($past(pin_out, 2) & ~$past(pin_oe_n, 2)))) else $error("port read mix");
  chk_empty_read: assert property (rd_take && unmapped |-> ##2 done && rsp_data == UNMAPPED_READ)
    else $error("unmapped read value");
  chk_dir_write: assert property (wr_take && cmd_addr == PORT_DIR_ADR |=> ##[0:2] pin_oe_n == ~last_wd)
    else $error("direction not applied");
  chk_latch_write: assert property (wr_take && cmd_addr == PORT_DATA_ADR |=> ##[0:2] pin_out == last_wd)
    else $error("latch not driven");
  chk_bit_atomic: assert property (bit_take |=> (!cmd_ready && !done) [*3] ##1 done)
    else $error("bit op not atomic");
  chk_move_zero: assert property (take && cmd_op == OP_MOVE && cmd_data == 8'h00 |-> ##2 done)
    else $error("empty move timing");
endmodule : cpusr_sva

bind cpusr_core cpusr_sva u_cpusr_sva (.ref_clk(ref_clk), .nrst(nrst), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
  .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_ready(cmd_ready), .done(done), .rsp_data(rsp_data),
  .halt_req(halt_req), .exc_req(exc_req), .cpu_state_code(cpu_state_code), .pin_in(pin_in),
  .pin_out(pin_out), .pin_oe_n(pin_oe_n));

// >>> cpusr_pins.sv
// far-side model: outside sources on the eight port pins
`timescale 1ns/1ps
module cpusr_pins (
  // level each outside source puts on its pin
  input  wire logic [7:0] ext_level,
  // device side of the pins
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe_n,
  output logic      [7:0] pin_in
);
  // sources back off where the device drives, so no contention is modelled
  assign pin_in = (pin_out & ~pin_oe_n) | (ext_level & pin_oe_n);
endmodule : cpusr_pins

// >>> tb_cpu_state_and_rmw_port_access.sv
// self-checking bench for the cpu state and read-modify-write core
`timescale 1ns/1ps
module tb_cpu_state_and_rmw_port_access import cpusr_pkg::*;;
  logic        ref_clk = 1'b0, nrst = 1'b0, cmd_valid = 1'b0, halt_req = 1'b0;
  logic        halt_standby = 1'b0, wake = 1'b0, exc_req = 1'b0;
  logic [2:0]  cmd_op = 3'h0, cmd_bit = 3'h0;
  logic [15:0] cmd_addr = 16'h0, cmd_dst = 16'h0;
  logic [7:0]  cmd_data = 8'h00, ext_level = 8'h40, rnd = 8'h02;
  logic        cmd_ready, done, standby_mode;
  logic [7:0]  rsp_data, pin_in, pin_out, pin_oe_n, b, m, v;
  logic [1:0]  cpu_state_code;
  logic [7:0]  mem [4];
  logic [8:0]  expq [$];
  logic [8:0]  note;
  int          failures = 0;
  int          n_checks = 0;
  always #2.5 ref_clk = ~ref_clk;
  ////////////////////////////////////////////////////////////////////////////////
  cpusr_core u_cpusr_core (.ref_clk(ref_clk), .nrst(nrst), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_addr(cmd_addr), .cmd_dst(cmd_dst), .cmd_bit(cmd_bit), .cmd_data(cmd_data), .cmd_ready(cmd_ready),
    .done(done), .rsp_data(rsp_data), .halt_req(halt_req), .halt_standby(halt_standby), .wake(wake),
    .exc_req(exc_req), .cpu_state_code(cpu_state_code), .standby_mode(standby_mode), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n));
  cpusr_pins u_cpusr_pins (.ext_level(ext_level), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_in(pin_in));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  task automatic wrap_up;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : wrap_up
  task automatic fail(input string msg);
    failures++;
    $display("ERROR %0t %s", $time, msg);
  endtask : fail
  task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_checks++;
    if (got !== exp) fail(what);
  endtask : check8
  // bounded waits; all stimulus moves on falling edges
  task automatic wait_code(input logic [1:0] c);
    int i;
    for (i = 0; i < 100 && cpu_state_code !== c; i++) @(negedge ref_clk);
    n_checks++;
    if (i == 100) begin
      fail("state timeout");
      wrap_up();
    end
  endtask : wait_code
  task automatic wait_ready;
    int i;
    for (i = 0; i < 100 && cmd_ready !== 1'b1; i++) @(negedge ref_clk);
    if (i == 100) begin
      fail("ready timeout");
      wrap_up();
    end
  endtask : wait_ready
  // one command, held through its taking edge; the expected answer is noted first
  task automatic issue(input logic [2:0] op, input logic [15:0] adr, input logic [15:0] dst,
                       input logic [2:0] bn, input logic [7:0] d, input logic [8:0] exp);
    wait_ready();
    cmd_op = op;
    cmd_addr = adr;
    cmd_dst = dst;
    cmd_bit = bn;
    cmd_data = d;
    cmd_valid = 1'b1;
    expq.push_back(exp);
    @(negedge ref_clk);
    cmd_valid = 1'b0;
  endtask : issue
  task automatic wr(input logic [15:0] adr, input logic [7:0] d);
    issue(OP_WRITE, adr, 16'h0, 3'h0, d, 9'h000);
  endtask : wr
  task automatic rd(input logic [15:0] adr, input logic [7:0] exp);
    issue(OP_READ, adr, 16'h0, 3'h0, 8'h00, {1'b1, exp});
  endtask : rd
  // each done retires the oldest note and, where the note is flagged, compares the byte it carries
  always @(negedge ref_clk) begin
    if (done === 1'b1) begin
      if (expq.size() == 0) fail("done without command");
      else begin
        note = expq.pop_front();
        if (note[8]) check8(rsp_data, note[7:0], "answer byte");
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(negedge ref_clk);
    nrst = 1'b1;
    wait_ready();
    check8(pin_oe_n, 8'hff, "pins not inputs");
    check8(pin_out, LATCH_RESET, "latch not clear");
    for (int k = 0; k < 4; k++) begin
      rnd = lfsr(rnd);
      mem[k] = rnd;
      wr(RAM_BASE + 16'(k), rnd);
      rd(RAM_BASE + 16'(k), rnd);
    end
    wr(16'h1234, 8'haa);
    rd(16'h1234, UNMAPPED_READ);
    wr(16'h0010, 8'haa);
    rd(16'h0010, ROM_FILL);
    // the dropped rom write lands on ram entry 0 if the decode only looked at low bits
    rd(RAM_BASE, mem[0]);
    $display("test memory map done");
    // destination end stays inside the space, so no pointer wrap
    wr(RAM_BASE + 16'hc, 8'h5a);
    issue(OP_MOVE, RAM_BASE, RAM_BASE + 16'h8, 3'h0, 8'h04, 9'h000);
    issue(OP_MOVE, RAM_BASE, RAM_BASE + 16'hc, 3'h0, 8'h00, 9'h000);
    for (int k = 0; k < 4; k++) rd(RAM_BASE + 16'h8 + 16'(k), mem[k]);
    rd(RAM_BASE + 16'hc, 8'h5a);
    $display("test block move done");
    for (int op = 2; op < 7; op++) begin
      rnd = lfsr(rnd);
      b = lfsr(rnd);
      m = 8'h01 << rnd[2:0];
      case (3'(op))
        OP_BIT_SET_INSTRUCTION: v = b | m;
        OP_BIT_CLEAR_INSTRUCTION: v = b & ~m;
        OP_BIT_INVERT_INSTRUCTION: v = b ^ m;
        OP_BST:  v = rnd[3] ? (b | m) : (b & ~m);
        default: v = rnd[3] ? (b & ~m) : (b | m);
      endcase
      wr(RAM_BASE + 16'hf, b);
      issue(3'(op), RAM_BASE + 16'hf, 16'h0, rnd[2:0], {7'h00, rnd[3]}, {1'b1, v});
      rd(RAM_BASE + 16'hf, v);
    end
    $display("test bit ops done");
    // pins 7 and 6 inputs from outside; a bit set on the port rewrites them from the pins
    wr(PORT_DIR_ADR, 8'h3f);
    wr(PORT_DATA_ADR, 8'h80);
    rd(PORT_DIR_ADR, DIR_READ);
    rd(PORT_DATA_ADR, 8'h40);
    issue(OP_BIT_SET_INSTRUCTION, PORT_DATA_ADR, 16'h0, 3'h0, 8'h00, {1'b1, 8'h41});
    wait_ready();
    check8(pin_out, 8'h41, "latch after bit set");
    check8(pin_oe_n, 8'hc0, "output enables");
    wr(RAM_BASE, 8'h80);
    issue(OP_BIT_SET_INSTRUCTION, RAM_BASE, 16'h0, 3'h0, 8'h00, {1'b1, 8'h81});
    wr(PORT_DATA_ADR, 8'h81);
    rnd = lfsr(rnd);
    ext_level = rnd;
    rd(PORT_DATA_ADR, (rnd & 8'hc0) | 8'h01);
    check8(pin_out, 8'h81, "latch after shadow write");
    issue(OP_BIT_CLEAR_INSTRUCTION, PORT_DIR_ADR, 16'h0, 3'h0, 8'h00, {1'b1, 8'hfe});
    wait_ready();
    check8(pin_oe_n, 8'h01, "direction after bit clear");
    $display("test port done");
    // standby halt, wake through exception, then a lone exception request
    halt_standby = 1'b1;
    halt_req = 1'b1;
    wait_code(CODE_HALT);
    halt_req = 1'b0;
    check8({7'h00, standby_mode}, 8'h01, "standby not kept");
    wake = 1'b1;
    wait_code(CODE_EXCEPT);
    wake = 1'b0;
    wait_code(CODE_EXEC);
    exc_req = 1'b1;
    wait_code(CODE_EXCEPT);
    exc_req = 1'b0;
    wait_code(CODE_EXEC);
    // exception wins over a halt raised with it; the halt then follows as a sleep
    halt_standby = 1'b0;
    halt_req = 1'b1;
    exc_req = 1'b1;
    wait_code(CODE_EXCEPT);
    exc_req = 1'b0;
    wait_code(CODE_HALT);
    halt_req = 1'b0;
    check8({7'h00, standby_mode}, 8'h00, "sleep not kept");
    wake = 1'b1;
    wait_code(CODE_EXCEPT);
    wake = 1'b0;
    wait_code(CODE_EXEC);
    // a command whose done never came would leave its note behind unchecked
    n_checks++;
    if (expq.size() != 0) fail("command without done");
    $display("test states done");
    wrap_up();
  end
endmodule : tb_cpu_state_and_rmw_port_access
